// ### dv/apb_host.sv
// Host model that issues register transfers over the peripheral bus
`timescale 1ns/100ps
module apb_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [9:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 10'h000;
    pwdata  = 32'h00000000;
  end

  // ****************************************
  // One transfer: setup, then access until pready
  // ****************************************
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // apb_host

// ### dv/tb_baud_select_and_receiver_reset.sv
// Self-checking bench for bit clock selection and receiver reset control
`timescale 1ns/100ps
module tb_baud_select_and_receiver_reset;
  // ****************************************
  // Settings and signals
  // ****************************************
  localparam int unsigned CLK   = 1_600_000;
  localparam int          LIMIT = 60000;
  localparam logic [9:0]  A_CLK = {baud_pkg::IDX_CLKSEL, 2'b00};
  localparam logic [9:0]  A_AUX = {baud_pkg::IDX_AUX, 2'b00};
  localparam logic [9:0]  A_TGL = {baud_pkg::IDX_EXT_TOGGLE, 2'b00};
  localparam logic [9:0]  A_MOD = {baud_pkg::IDX_MODE, 2'b00};
  localparam logic [9:0]  A_CMD = {baud_pkg::IDX_CMD, 2'b00};
  localparam logic [9:0]  A_STA = {baud_pkg::IDX_STATUS, 2'b00};
  localparam logic [9:0]  A_OUT = {baud_pkg::IDX_OUTPORT, 2'b00};
  localparam logic [9:0]  A_T1X = {baud_pkg::IDX_TEST_1X, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_now, rerr;
  logic        timer_tick = 1'b0;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rdv, n;
  logic [1:0]  ext_clk = 2'h0;
  logic [1:0]  rx_bit_tick, tx_bit_tick, rx_enabled, rx_active;
  logic [7:0]  op_pins;
  int          n_errors, compares;
  int          cyc = 0;
  int unsigned cs_code [9] = '{6, 6, 3, 3, 12, 12, 0, 0, 7};
  int unsigned cs_set  [9] = '{0, 1, 0, 1, 0, 1, 0, 1, 1};
  int unsigned cs_ext  [9] = '{0, 1, 1, 1, 0, 0, 1, 1, 1};
  int unsigned cs_rate [9] = '{12000, 1152000, 192000, 144000, 384000, 192000, 48000, 72000,
                               20000};

  baud_select_rx_reset #(.CLK_HZ(CLK)) i_baud_select_rx_reset (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .ext_clk(ext_clk), .rx_bit_tick(rx_bit_tick),
    .tx_bit_tick(tx_bit_tick), .rx_enabled(rx_enabled), .rx_active(rx_active),
    .op_pins(op_pins));
  apb_host i_apb_host (
    .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ****************************************
  // Clock, side inputs and timeout
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    timer_tick <= (cyc[1:0] == 2'h3);
    if (cyc % 5 == 4) begin
      ext_clk <= ~ext_clk;
    end
    if (cyc >= LIMIT) begin
      n_errors++;
      conclude();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    i_apb_host.xfer(1'b1, a, d, rdv, rerr);
  endtask
  task automatic rd(input logic [9:0] a);
    i_apb_host.xfer(1'b0, a, 32'h00000000, rdv, rerr);
  endtask
  function automatic logic [31:0] per(input int unsigned r);
    return 16 * ((CLK * 10 + 8 * r) / (16 * r));
  endfunction
  function automatic logic tick(input int w);
    return w ? tx_bit_tick[1] : rx_bit_tick[0];
  endfunction
  task automatic period(input int w);
    n = 0;
    repeat (2) begin
      do @(negedge pclk); while (tick(w) !== 1'b1);
    end
    do begin
      @(negedge pclk);
      n = n + 1;
    end while (tick(w) !== 1'b1);
  endtask
  task automatic set_ext(input logic v);
    if (ext_now !== v) begin
      rd(A_TGL);
      check(rdv, {31'h0, ext_now}, "toggle old state");
      ext_now = v;
    end
    rd(A_STA);
    check({31'h0, rdv[baud_pkg::ST_EXT_BIT]}, {31'h0, v}, "ext state");
  endtask
  task automatic set_rate(input logic [3:0] c, input logic s, input logic e);
    wr(A_AUX, {31'h0, s});
    set_ext(e);
    wr(A_CLK, 32'h0000ffff);
    wr(A_CLK, {16'h0, c, c, c, c});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(A_STA);
    check(rdv, 32'h0, "status after reset");
    rd(A_CLK);
    check(rdv, 32'h0, "clock select after reset");
    check({24'h0, op_pins}, 32'hff, "port after reset");
  endtask
  task automatic t_rates();
    for (int i = 0; i < 9; i++) begin
      set_rate(cs_code[i][3:0], cs_set[i][0], cs_ext[i][0]);
      period(0);
      check(n, per(cs_rate[i]), "rx A period");
      period(1);
      check(n, per(cs_rate[i]), "tx B period");
    end
  endtask
  task automatic t_sources();
    set_rate(baud_pkg::CODE_TIMER, 1'b0, 1'b0);
    period(0);
    check(n, 32'd64, "timer period");
    set_rate(baud_pkg::CODE_EXT16, 1'b0, 1'b0);
    period(1);
    check(n, 32'd160, "ext 16x period");
    set_rate(baud_pkg::CODE_EXT1X, 1'b0, 1'b0);
    period(0);
    check(n, 32'd10, "ext 1x period");
  endtask
  task automatic t_rx_normal();
    wr(A_MOD, 32'h0);
    wr(A_CLK, 32'h1234);
    wr(A_CMD, 32'h11);
    @(negedge pclk);
    check({30'h0, rx_enabled}, 32'h3, "enable both");
    wr(A_CMD, 32'h04);
    @(negedge pclk);
    check({30'h0, rx_enabled}, 32'h2, "reset A");
    rd(A_CLK);
    check(rdv, 32'h1234, "programming kept");
    wr(A_CMD, 32'h01);
    @(negedge pclk);
    check({30'h0, rx_enabled}, 32'h3, "re-enable A");
    wr(A_CMD, 32'h20);
    @(negedge pclk);
    check({30'h0, rx_enabled}, 32'h1, "disable B");
  endtask
  task automatic t_wakeup();
    wr(A_MOD, 32'h3);
    wr(A_CMD, 32'h66);
    @(negedge pclk);
    check({28'h0, rx_active, rx_enabled}, 32'h5, "wake-up blocks reset");
    wr(A_MOD, 32'h0);
    wr(A_CMD, 32'h04);
    wr(A_MOD, 32'h3);
    @(negedge pclk);
    check({28'h0, rx_active, rx_enabled}, 32'h4, "wake-up reset sequence");
  endtask
  task automatic t_force();
    wr(A_MOD, 32'h0);
    wr(A_CMD, 32'h01);
    wr(A_OUT, 32'h5a);
    repeat (2) @(negedge pclk);
    check({24'h0, op_pins}, 32'ha5, "port normal");
    wr(A_T1X, 32'h1);
    rd(A_STA);
    check({31'h0, rdv[baud_pkg::ST_FORCE_BIT]}, 32'h1, "1x test state");
    set_rate(4'h6, 1'b0, 1'b0);
    period(0);
    check(n, per(12000) / 16, "forced 1x period");
    @(negedge pclk);
    check({28'h0, op_pins[7:4]}, 32'h5, "port internal nodes");
    wr(A_T1X, 32'h0);
    repeat (2) @(negedge pclk);
    check({24'h0, op_pins}, 32'ha5, "port back to normal");
  endtask
  task automatic t_unmapped();
    rd(10'h01c);
    check({rerr, rdv[30:0]}, 32'h80000000, "unmapped read");
    rd(10'h001);
    check({rerr, rdv[30:0]}, 32'h80000000, "unaligned read");
    wr(10'h024, 32'h1);
    check({31'h0, rerr}, 32'h1, "unmapped write");
  endtask
  task automatic t_rereset();
    set_ext(1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    ext_now = 1'b0;
    rd(A_STA);
    check(rdv, 32'h0, "status after second reset");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    ext_now = 1'b0;
    n_errors = 0;
    compares = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rates();
    t_sources();
    t_rx_normal();
    t_wakeup();
    t_force();
    t_unmapped();
    t_rereset();
    conclude();
  end
endmodule // tb_baud_select_and_receiver_reset

// ### src/baud_pkg.sv
// Constants for bit clock selection and receiver reset control
package baud_pkg;
  // ****************************************
  // Bus map (index, byte address is index * 4)
  // ****************************************
  localparam logic [7:0] IDX_CLKSEL     = 8'h00;
  localparam logic [7:0] IDX_AUX        = 8'h01;
  localparam logic [7:0] IDX_EXT_TOGGLE = 8'h02;
  localparam logic [7:0] IDX_MODE       = 8'h03;
  localparam logic [7:0] IDX_CMD        = 8'h04;
  localparam logic [7:0] IDX_STATUS     = 8'h05;
  localparam logic [7:0] IDX_OUTPORT    = 8'h06;
  localparam logic [7:0] IDX_TEST_1X    = 8'h0a;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          CMD_ENABLE_BIT  = 0;
  localparam int          CMD_DISABLE_BIT = 1;
  localparam int          CMD_RESET_BIT   = 2;
  localparam int          CMD_CH_STRIDE   = 4;
  localparam int          ST_EXT_BIT      = 4;
  localparam int          ST_FORCE_BIT    = 5;
  localparam logic [15:0] CLKSEL_RESET    = 16'h0000;
  localparam logic [3:0]  MODE_RESET      = 4'h0;
  localparam logic [7:0]  OUTPORT_RESET   = 8'h00;
  localparam logic [1:0]  PARITY_WAKEUP   = 2'h3;

  // ****************************************
  // Clock select codes
  // ****************************************
  localparam logic [3:0] CODE_TIMER = 4'hd;
  localparam logic [3:0] CODE_EXT16 = 4'he;
  localparam logic [3:0] CODE_EXT1X = 4'hf;
  localparam logic [3:0] SUB16_LAST = 4'hf;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ_DEFAULT = 100_000_000;
  localparam int          DIV_W          = 20;

  // Rates in tenths of a baud
  localparam int unsigned R50    = 500;
  localparam int unsigned R75    = 750;
  localparam int unsigned R110   = 1100;
  localparam int unsigned R134   = 1345;
  localparam int unsigned R150   = 1500;
  localparam int unsigned R200   = 2000;
  localparam int unsigned R300   = 3000;
  localparam int unsigned R600   = 6000;
  localparam int unsigned R880   = 8800;
  localparam int unsigned R1050  = 10500;
  localparam int unsigned R1076  = 10760;
  localparam int unsigned R1200  = 12000;
  localparam int unsigned R1800  = 18000;
  localparam int unsigned R2000  = 20000;
  localparam int unsigned R2400  = 24000;
  localparam int unsigned R4800  = 48000;
  localparam int unsigned R7200  = 72000;
  localparam int unsigned R9600  = 96000;
  localparam int unsigned R14k4  = 144000;
  localparam int unsigned R19k2  = 192000;
  localparam int unsigned R28k8  = 288000;
  localparam int unsigned R38k4  = 384000;
  localparam int unsigned R57k6  = 576000;
  localparam int unsigned R115k2 = 1152000;

  // Fixed rate for a code, rate set and table choice
  function automatic int unsigned rate10(input logic [3:0] code, input logic set,
                                         input logic ext);
    int unsigned r;
    r = R9600;
    case (code)
      4'h0:    r = ext ? (set ? R7200 : R4800) : (set ? R75 : R50);
      4'h1:    r = ext ? R880 : R110;
      4'h2:    r = ext ? R1076 : R134;
      4'h3:    r = ext ? (set ? R14k4 : R19k2) : (set ? R150 : R200);
      4'h4:    r = ext ? R28k8 : R300;
      4'h5:    r = ext ? R57k6 : R600;
      4'h6:    r = ext ? R115k2 : R1200;
      4'h7:    r = set ? R2000 : R1050;
      4'h8:    r = ext ? R57k6 : R2400;
      4'h9:    r = R4800;
      4'ha:    r = ext ? (set ? R14k4 : R57k6) : (set ? R1800 : R7200);
      4'hb:    r = R9600;
      4'hc:    r = set ? R19k2 : R38k4;
      default: r = R9600;
    endcase
    return r;
  endfunction

  // Clock cycles per 16x tick, rounded to nearest
  function automatic int unsigned div_of(input int unsigned clk_hz, input int unsigned r10);
    return (clk_hz * 10 + 8 * r10) / (16 * r10);
  endfunction
endpackage

// ### src/baud_select_rx_reset.sv
// APB bit clock selection, test modes and receiver reset control
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
// Function
// - Clock code picks fixed, timer, ext 16x or 1x
// - Rate set bit picks between two tables
// - Extended test mode swaps alternate rate table
// - Each read at index 2 toggles extended mode
// - Extended mode is one device wide setting
// - Index A test mode forces 1x clocking
// - Index A test mode drives ports internally
// - Receiver reset then enable keeps programming
// - Wake-up parity code blocks disable and reset
module baud_select_rx_reset #(
  parameter int unsigned CLK_HZ = baud_pkg::CLK_HZ_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_tick,
  input  wire logic [1:0]  ext_clk,
  output logic [1:0]       rx_bit_tick,
  output logic [1:0]       tx_bit_tick,
  output logic [1:0]       rx_enabled,
  output logic [1:0]       rx_active,
  output logic [7:0]       op_pins
);
  logic [15:0] clksel;
  logic        rate_set_select;
  logic [3:0]  parity_mode_field;
  logic [7:0]  outport;
  logic        ext_mode;
  logic        force_1x;
  logic [1:0]  ext_meta;
  logic [1:0]  ext_sync;
  logic [1:0]  ext_prev;
  logic [1:0]  ext_edge;
  logic [7:0]  idx;
  logic        mapped;
  logic        wr;
  logic        rd;
  logic [1:0]  wakeup;
  logic [31:0] next_prdata;

  // ****************************************
  // APB decode
  // ****************************************
  assign idx    = paddr[9:2];
  assign mapped = (paddr[1:0] == 2'h0) &&
                  (idx <= baud_pkg::IDX_OUTPORT || idx == baud_pkg::IDX_TEST_1X);
  assign wr     = psel && penable && pwrite && mapped;
  assign rd     = psel && penable && !pwrite && mapped;
  assign pready = 1'b1;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (idx)
      baud_pkg::IDX_CLKSEL:     next_prdata[15:0] = clksel;
      baud_pkg::IDX_AUX:        next_prdata[0]    = rate_set_select;
      baud_pkg::IDX_EXT_TOGGLE: next_prdata[0]    = ext_mode;
      baud_pkg::IDX_MODE:       next_prdata[3:0]  = parity_mode_field;
      baud_pkg::IDX_STATUS:     next_prdata[5:0]  = {force_1x, ext_mode, rx_active, rx_enabled};
      baud_pkg::IDX_OUTPORT:    next_prdata[7:0]  = outport;
      baud_pkg::IDX_TEST_1X:    next_prdata[0]    = force_1x;
      default:                  next_prdata       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= (pwrite || !mapped) ? 32'h0000_0000 : next_prdata;
      pslverr <= !mapped;
    end
  end

  // ****************************************
  // Programming registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clksel            <= baud_pkg::CLKSEL_RESET;
      rate_set_select   <= 1'b0;
      parity_mode_field <= baud_pkg::MODE_RESET;
      outport           <= baud_pkg::OUTPORT_RESET;
      force_1x          <= 1'b0;
    end else if (wr) begin
      case (idx)
        baud_pkg::IDX_CLKSEL:  clksel            <= pwdata[15:0];
        baud_pkg::IDX_AUX:     rate_set_select   <= pwdata[0];
        baud_pkg::IDX_MODE:    parity_mode_field <= pwdata[3:0];
        baud_pkg::IDX_OUTPORT: outport           <= pwdata[7:0];
        baud_pkg::IDX_TEST_1X: force_1x          <= pwdata[0];
        default:               clksel            <= clksel;
      endcase
    end
  end

  // ****************************************
  // Extended rate test mode
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_mode <= 1'b0;
    end else if (rd && idx == baud_pkg::IDX_EXT_TOGGLE) begin
      ext_mode <= !ext_mode;
    end
  end

  // ****************************************
  // Receiver enable and reset
  // ****************************************
  for (genvar ch = 0; ch < 2; ch++) begin : g_rx
    localparam int B = ch * baud_pkg::CMD_CH_STRIDE;
    assign wakeup[ch] = parity_mode_field[2*ch +: 2] == baud_pkg::PARITY_WAKEUP;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_enabled[ch] <= 1'b0;
      end else if (wr && idx == baud_pkg::IDX_CMD) begin
        if ((pwdata[B + baud_pkg::CMD_RESET_BIT] || pwdata[B + baud_pkg::CMD_DISABLE_BIT])
            && !wakeup[ch]) begin
          rx_enabled[ch] <= 1'b0;
        end else if (pwdata[B + baud_pkg::CMD_ENABLE_BIT]) begin
          rx_enabled[ch] <= 1'b1;
        end
      end
    end

    assign rx_active[ch] = rx_enabled[ch] || wakeup[ch];

    a_rx_enable: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && idx == baud_pkg::IDX_CMD && pwdata[B + baud_pkg::CMD_ENABLE_BIT]
       && !pwdata[B + baud_pkg::CMD_RESET_BIT] && !pwdata[B + baud_pkg::CMD_DISABLE_BIT])
      |=> rx_enabled[ch])
      else $error("enable command did not enable receiver");
    a_rx_reset: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && idx == baud_pkg::IDX_CMD && pwdata[B + baud_pkg::CMD_RESET_BIT] && !wakeup[ch])
      |=> !rx_enabled[ch])
      else $error("reset command left receiver enabled");
    a_wake_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (wakeup[ch] && rx_enabled[ch]) |=> rx_enabled[ch])
      else $error("receiver left enabled state in wake-up mode");

    bit_clock_select #(.CLK_HZ(CLK_HZ)) u_rx (
      .pclk            (pclk),
      .presetn         (presetn),
      .code            (clksel[8*ch + 4 +: 4]),
      .rate_set_select (rate_set_select),
      .ext_mode        (ext_mode),
      .force_1x        (force_1x),
      .timer_tick      (timer_tick),
      .ext_edge        (ext_edge[ch]),
      .bit_tick        (rx_bit_tick[ch])
    );
    bit_clock_select #(.CLK_HZ(CLK_HZ)) u_tx (
      .pclk            (pclk),
      .presetn         (presetn),
      .code            (clksel[8*ch +: 4]),
      .rate_set_select (rate_set_select),
      .ext_mode        (ext_mode),
      .force_1x        (force_1x),
      .timer_tick      (timer_tick),
      .ext_edge        (ext_edge[ch]),
      .bit_tick        (tx_bit_tick[ch])
    );
  end

  // ****************************************
  // External clock pins and output port
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= 2'h0;
      ext_sync <= 2'h0;
      ext_prev <= 2'h0;
    end else begin
      ext_meta <= ext_clk;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end
  assign ext_edge = ext_sync & ~ext_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_pins <= 8'hff;
    end else if (force_1x) begin
      op_pins <= {rx_active, rx_enabled, rx_bit_tick, tx_bit_tick};
    end else begin
      op_pins <= ~outport;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_toggle_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && idx == baud_pkg::IDX_EXT_TOGGLE) |=> ext_mode != $past(ext_mode))
    else $error("read at toggle address did not flip extended mode");
  a_ext_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(rd && idx == baud_pkg::IDX_EXT_TOGGLE) |=> $stable(ext_mode))
    else $error("extended mode changed without toggle read");
  a_ext_reset: assert property (@(posedge pclk)
    $rose(presetn) |-> !ext_mode)
    else $error("extended mode set after reset");
  a_force_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == baud_pkg::IDX_TEST_1X) |=> force_1x == $past(pwdata[0]))
    else $error("1x test mode not taken from write");
  a_port_test: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 $past(force_1x) |-> op_pins[7:6] == $past(rx_active))
    else $error("output port not driven from internal nodes");
  a_keep_prog: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == baud_pkg::IDX_CMD) |=> $stable(clksel) && $stable(parity_mode_field))
    else $error("receiver command altered programming");
  a_wake_block: assert property (@(posedge pclk) disable iff (!presetn)
    (wakeup[0] && rx_enabled[0]) |=> rx_enabled[0] || !$past(wakeup[0]))
    else $error("receiver disabled while in wake-up mode");
  a_port_normal: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 !$past(force_1x) |-> op_pins == ~$past(outport))
    else $error("output port not driven from port register");
  a_toggle_old: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && idx == baud_pkg::IDX_EXT_TOGGLE) |-> prdata[0] == ext_mode)
    else $error("toggle read did not return prior state");
  a_force_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && idx == baud_pkg::IDX_TEST_1X) |=> $stable(force_1x))
    else $error("1x test mode changed without write");
  c_toggle: cover property (@(posedge pclk) disable iff (!presetn) $rose(ext_mode));
  c_force: cover property (@(posedge pclk) disable iff (!presetn) force_1x && rx_bit_tick[0]);
  c_rx_reset: cover property (@(posedge pclk) disable iff (!presetn) $fell(rx_enabled[1]));
endmodule // baud_select_rx_reset

// ### src/bit_clock_select.sv
// One bit clock selector: 16x tick source and bit tick
`timescale 1ns/100ps
module bit_clock_select #(
  parameter int unsigned CLK_HZ = baud_pkg::CLK_HZ_DEFAULT
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] code,
  input  wire logic       rate_set_select,
  input  wire logic       ext_mode,
  input  wire logic       force_1x,
  input  wire logic       timer_tick,
  input  wire logic       ext_edge,
  output logic            bit_tick
);
  localparam int W = baud_pkg::DIV_W;

  logic         fixed;
  logic [W-1:0] div;
  logic [W-1:0] cnt;
  logic [5:0]   cfg;
  logic [5:0]   cfg_prev;
  logic         tick16;
  logic [3:0]   sub16;

  // ****************************************
  // Rate divider
  // ****************************************
  assign fixed = code < baud_pkg::CODE_TIMER;
  assign div   = W'(baud_pkg::div_of(CLK_HZ,
                   baud_pkg::rate10(code, rate_set_select, ext_mode)));
  assign cfg   = {code, rate_set_select, ext_mode};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= '0;
      cfg_prev <= '0;
    end else begin
      cfg_prev <= cfg;
      if (cfg != cfg_prev || cnt >= div - W'(1)) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + W'(1);
      end
    end
  end

  always_comb begin
    tick16 = 1'b0;
    case (code)
      baud_pkg::CODE_TIMER: tick16 = timer_tick;
      baud_pkg::CODE_EXT16: tick16 = ext_edge;
      baud_pkg::CODE_EXT1X: tick16 = ext_edge;
      default:              tick16 = (cfg == cfg_prev) && (cnt == div - W'(1));
    endcase
  end

  // ****************************************
  // Divide by 16 or pass through in 1x
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub16 <= '0;
    end else if (tick16) begin
      sub16 <= sub16 + 4'h1;
    end
  end

  assign bit_tick = (code == baud_pkg::CODE_EXT1X || force_1x) ? tick16
                  : (tick16 && sub16 == baud_pkg::SUB16_LAST);

  // ****************************************
  // Assertions
  // ****************************************
  logic [W-1:0] gap;
  logic         gap_ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap    <= '0;
      gap_ok <= 1'b0;
    end else if (cfg != cfg_prev || !fixed) begin
      gap    <= '0;
      gap_ok <= 1'b0;
    end else if (tick16) begin
      gap    <= '0;
      gap_ok <= 1'b1;
    end else begin
      gap    <= gap + W'(1);
    end
  end

  a_fixed_period: assert property (@(posedge pclk) disable iff (!presetn)
    (tick16 && fixed && gap_ok) |-> gap == div - W'(1))
    else $error("fixed rate tick spacing differs from divisor");
  a_ext_onex: assert property (@(posedge pclk) disable iff (!presetn)
    (code == baud_pkg::CODE_EXT1X && ext_edge) |-> bit_tick)
    else $error("external 1x edge gave no bit tick");
  a_force_onex: assert property (@(posedge pclk) disable iff (!presetn)
    (force_1x && tick16) |-> bit_tick)
    else $error("forced 1x mode did not pass 16x tick");
  c_sixteen: cover property (@(posedge pclk) disable iff (!presetn)
    !force_1x && fixed && bit_tick);
endmodule // bit_clock_select
